// File: verilog/sfp_pkg.sv
package sfp_pkg;
    // time base
    localparam int unsigned CLK_PERIOD_NS = 20;       // 50 MHz
    localparam int unsigned STEP_TIME_NS  = 32000;    // 0.032 ms step
    localparam int unsigned TICK_CYC      = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam logic [63:0] STEP_US       = 64'h20;   // step in us
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_RANGE  = 8'h04;
    localparam logic [7:0] OFS_CAL    = 8'h08;
    localparam logic [7:0] OFS_PFACT  = 8'h0c;
    localparam logic [7:0] OFS_WIDTH  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK   = 8'h18;
    localparam logic [7:0] OFS_TOT_LO = 8'h1c;
    localparam logic [7:0] OFS_TOT_HI = 8'h20;
    localparam logic [7:0] OFS_PCOUNT = 8'h24;
    // ctrl fields
    localparam int unsigned CTRL_EN_BIT     = 0;
    localparam int unsigned CTRL_ACTIVE_BIT = 1;
    // status bit positions
    localparam int unsigned ST_CLAMP   = 0;  // width cut to half period
    localparam int unsigned ST_FLOW    = 1;  // frequency too low (-41)
    localparam int unsigned ST_FHIGH   = 2;  // frequency too high (-40)
    localparam int unsigned ST_WREJ    = 3;  // width entry too small or too large (46)
    localparam int unsigned ST_RREJ    = 4;  // range out of bounds
    localparam int unsigned ST_PREJ    = 5;  // pulse factor out of bounds
    localparam int unsigned ST_RATIO   = 6;  // active pulse/pause < 1:4
    localparam int unsigned ST_OWED    = 7;  // pulse backlog overflow
    // reset values
    localparam logic [1:0]  CTRL_RST  = 2'h0;
    localparam logic [31:0] CAL_RST   = 32'h0001_86a0; // 100 units/s
    localparam logic [31:0] RANGE_RST = 32'h0001_86a0;
    localparam logic [31:0] PF_RST    = 32'h0000_03e8; // 1 pulse/unit
    localparam logic [16:0] PW_RST    = 17'h003aa;     // 30 ms in steps
    localparam logic [7:0]  MASK_RST  = 8'h00;
    // entry limits (width in us, factor in milli-pulses per unit)
    localparam logic [31:0] PW_MIN_US = 32'd100;       // 0.1 ms
    localparam logic [31:0] PW_MAX_US = 32'd2000000;   // 2000 ms
    localparam logic [31:0] PF_MIN    = 32'd1;         // 0.001
    localparam logic [31:0] PF_MAX    = 32'd1000000;   // 1000
    localparam logic [35:0] RANGE_DIV = 36'd20;        // 0.05 of cal
    // frequency figures, product of range and factor is in micro-hertz
    localparam logic [95:0] ONE_PULSE  = 96'd1000000000000; // 1e12
    localparam logic [95:0] FLOW_UHZ   = 96'd160;        // 0.00016 Hz
    localparam logic [95:0] FHIGH_UHZ  = 96'd5000000000; // 5 kHz
    localparam logic [95:0] FACT_UHZ   = 96'd4000000;    // 4 Hz
    localparam logic [95:0] OVR_NUM    = 96'd13;         // 130 %
    localparam logic [95:0] OVR_DEN    = 96'd10;
    localparam logic [95:0] ENTRY_PCT  = 96'd8;          // 80 %
    localparam logic [95:0] RATIO_DIV  = 96'd5;          // 1:4
endpackage : sfp_pkg

// File: verilog/sfp_divider.sv
`timescale 1ns/10ps
// restoring divider, one quotient bit per enabled clock
module sfp_divider #(
    parameter int unsigned W = 64
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    // request
    input  wire logic         start_i,
    input  wire logic [W-1:0] num_i,
    input  wire logic [W-1:0] den_i,
    // answer
    output logic              done_o,
    output logic [W-1:0]      quot_o
);
    typedef struct packed {
        logic         busy;   // division running
        logic [7:0]   cnt;    // bits left
        logic [W-1:0] rem;    // partial remainder
        logic [W-1:0] quo;    // quotient, shifted in from the right
        logic [W-1:0] den;    // held divisor
        logic         done;   // one-cycle completion pulse
    } sfp_div_t;

    sfp_div_t s_q, s_d;
    logic [W:0] trial;        // remainder after shift

    // next state
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        trial    = {s_q.rem, s_q.quo[W-1]};
        if (start_i && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt  = 8'(W);
            s_d.rem  = '0;
            s_d.quo  = num_i;
            s_d.den  = den_i;
        end else if (s_q.busy) begin
            // shift one numerator bit into the remainder
            if (trial >= {1'b0, s_q.den}) begin
                s_d.rem = W'(trial - {1'b0, s_q.den});
                s_d.quo = {s_q.quo[W-2:0], 1'b1};
            end else begin
                s_d.rem = trial[W-1:0];
                s_d.quo = {s_q.quo[W-2:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - 8'h01;
            if (s_q.cnt == 8'h01) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign done_o = s_q.done;
    assign quot_o = s_q.quo;
endmodule // sfp_divider

// File: verilog/sfp_pulse_out.sv
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
module sfp_pulse_out
    import sfp_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // measured flow, milli-units per second, same clock domain
    input  wire logic [31:0] flow_i,
    // pulse output terminals and interrupt
    output logic             pulse_output_terminals_o,
    output logic             irq_o
);
    typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_LOW} sfp_pg_t;
    typedef enum logic [1:0] {CK_IDLE, CK_WAIT, CK_DONE} sfp_ck_t;

    typedef struct packed {
        logic        ack;       // bus acknowledge
        logic [31:0] dat;       // read data
        logic [1:0]  ctrl;      // enable and active-output mode
        logic [31:0] range;     // full_scale_flow, milli-units/s
        logic [31:0] cal;       // calibration full scale
        logic [31:0] pf;        // milli-pulses per unit
        logic [16:0] wset;      // entered width in steps
        logic [16:0] weff;      // width in use after clamping
        logic [7:0]  status;    // sticky events
        logic [7:0]  mask;      // interrupt enables
        logic        irq;       // interrupt level
        logic [63:0] tot;       // totalizer, nano-units
        logic [31:0] pcnt;      // pulses issued
        logic [63:0] acc;       // pulse accumulator, 1e-12 pulse
        logic [10:0] tick;      // step prescaler
        logic [7:0]  owed;      // pulses waiting for the output
        sfp_pg_t     pg;        // pulse generator state
        logic [16:0] pgcnt;     // steps left in pulse or pause
        logic        pin;       // output level
        sfp_ck_t     ck;        // settings check state
        logic        ck_pend;   // a setting changed
        logic        div_go;    // divider start pulse
    } sfp_state_t;

    sfp_state_t s_q, s_d;

    // merge a write into a register under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[8*i +: 8] = wd[8*i +: 8];
        end
        return r;
    endfunction

    // width in steps times full-scale frequency, scaled by a factor
    function automatic logic [95:0] wprod(input logic [16:0] w,
                                          input logic [63:0] f,
                                          input logic [95:0] k);
        return 96'(96'(w) * 96'(f) * STEP_US * k);
    endfunction

    logic        step;          // one 0.032 ms step
    logic        wr;            // write committed this edge
    logic [31:0] wval;          // merged write value
    logic [31:0] pw_us;         // width entry in us
    logic [16:0] pw_steps;      // entry rounded up to steps
    logic [63:0] fprod;         // full-scale frequency in micro-hertz
    logic [95:0] f130;          // frequency at 130 % times ten
    logic [7:0]  ev;            // events this cycle
    logic        div_done;      // clamp value ready
    logic [63:0] div_q;         // largest width at half period
    logic [63:0] add;           // accumulator increment

    // half-period limit: 1e12 / (2 * step * f)
    sfp_divider #(.W(64)) u_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .start_i (s_q.div_go),
        .num_i   (ONE_PULSE[63:0]),
        .den_i   (64'(fprod * 64'h2 * STEP_US)),
        .done_o  (div_done),
        .quot_o  (div_q)
    );

    // derived terms for the bus, the checker, the step prescaler and the accumulator
    always_comb begin
        step     = (s_q.tick == 11'(TICK_CYC - 1));
        wr       = cyc_i && stb_i && we_i && s_q.ack;
        wval     = merge(32'h0, dat_i, sel_i);
        pw_us    = wval;
        pw_steps = 17'((pw_us + 32'(STEP_US) - 32'h1) >> 5);
        fprod    = 64'(s_q.range) * 64'(s_q.pf);
        f130     = 96'(fprod) * OVR_NUM;
        add      = 64'(flow_i) * 64'(s_q.pf) * STEP_US;
    end

    // next state
    always_comb begin
        s_d        = s_q;
        ev         = 8'h00;
        s_d.div_go = 1'b0;
        s_d.dat    = 32'h0;
        // classic wishbone: answer one cycle after the request
        s_d.ack = cyc_i && stb_i && !s_q.ack;
        if (cyc_i && stb_i && !s_q.ack && !we_i) begin
            if (adr_i == OFS_CTRL) begin
                s_d.dat = {30'h0, s_q.ctrl};
            end else if (adr_i == OFS_RANGE) begin
                s_d.dat = s_q.range;
            end else if (adr_i == OFS_CAL) begin
                s_d.dat = s_q.cal;
            end else if (adr_i == OFS_PFACT) begin
                s_d.dat = s_q.pf;
            end else if (adr_i == OFS_WIDTH) begin
                s_d.dat = {15'h0, s_q.weff};
            end else if (adr_i == OFS_STATUS) begin
                s_d.dat = {24'h0, s_q.status};
            end else if (adr_i == OFS_MASK) begin
                s_d.dat = {24'h0, s_q.mask};
            end else if (adr_i == OFS_TOT_LO) begin
                s_d.dat = s_q.tot[31:0];
            end else if (adr_i == OFS_TOT_HI) begin
                s_d.dat = s_q.tot[63:32];
            end else if (adr_i == OFS_PCOUNT) begin
                s_d.dat = s_q.pcnt;
            end else begin
                s_d.dat = 32'h0;            // unmapped reads zero
            end
        end
        // writes take effect at the edge the master samples ack
        if (wr) begin
            if (adr_i == OFS_CTRL) begin
                s_d.ctrl = 2'(merge({30'h0, s_q.ctrl}, dat_i, sel_i));
            end else if (adr_i == OFS_RANGE) begin
                // keep old value when outside 0.05..1.0 of cal
                // forty bits so the times-twenty product cannot wrap
                if (40'(merge(s_q.range, dat_i, sel_i)) * 40'(RANGE_DIV)
                        >= 40'(s_q.cal)
                    && merge(s_q.range, dat_i, sel_i) <= s_q.cal) begin
                    s_d.range   = merge(s_q.range, dat_i, sel_i);
                    s_d.ck_pend = 1'b1;
                end else begin
                    ev[ST_RREJ] = 1'b1;
                end
            end else if (adr_i == OFS_CAL) begin
                s_d.cal     = merge(s_q.cal, dat_i, sel_i);
                s_d.ck_pend = 1'b1;
            end else if (adr_i == OFS_PFACT) begin
                if (merge(s_q.pf, dat_i, sel_i) >= PF_MIN
                    && merge(s_q.pf, dat_i, sel_i) <= PF_MAX) begin
                    // totalizer keeps flow units, so nothing rescales
                    s_d.pf      = merge(s_q.pf, dat_i, sel_i);
                    s_d.ck_pend = 1'b1;
                end else begin
                    ev[ST_PREJ] = 1'b1;
                end
            end else if (adr_i == OFS_WIDTH) begin
                if (pw_us < PW_MIN_US || pw_us > PW_MAX_US) begin
                    ev[ST_WREJ] = 1'b1;
                end else if (wprod(pw_steps, fprod, OVR_NUM)
                             > ONE_PULSE * ENTRY_PCT) begin
                    ev[ST_WREJ] = 1'b1;
                end else begin
                    s_d.wset    = pw_steps;
                    s_d.weff    = pw_steps;
                    s_d.ck_pend = 1'b1;
                end
            end else if (adr_i == OFS_STATUS) begin
                s_d.status = s_q.status & ~wval[7:0];           // w1c
            end else if (adr_i == OFS_MASK) begin
                s_d.mask = 8'(merge({24'h0, s_q.mask}, dat_i, sel_i));
            end
        end
        // settings check after any change of range, cal, factor or width
        case (s_q.ck)
            CK_IDLE: begin
                if (s_q.ck_pend && !wr) begin
                    s_d.ck_pend = 1'b0;
                    s_d.div_go  = 1'b1;
                    s_d.ck      = CK_WAIT;
                end
            end
            CK_WAIT: begin
                if (div_done) s_d.ck = CK_DONE;
            end
            default: begin
                s_d.ck = CK_IDLE;
                if (fprod == 64'h0 || 96'(fprod) < FLOW_UHZ) begin
                    ev[ST_FLOW] = 1'b1;
                end
                if (f130 > FHIGH_UHZ * OVR_DEN) begin
                    ev[ST_FHIGH] = 1'b1;
                end
                if (fprod != 64'h0
                    && wprod(s_q.wset, fprod, 96'h2) > ONE_PULSE) begin
                    s_d.weff = (div_q == 64'h0) ? 17'h1
                             : 17'(div_q);
                    ev[ST_CLAMP] = 1'b1;
                end
                if (s_q.ctrl[CTRL_ACTIVE_BIT] && fprod != 64'h0
                    && f130 <= FACT_UHZ * OVR_DEN
                    && wprod(s_q.wset, fprod, RATIO_DIV) < ONE_PULSE) begin
                    ev[ST_RATIO] = 1'b1;
                end
            end
        endcase
        // step prescaler
        s_d.tick = step ? 11'h0 : s_q.tick + 11'h1;
        if (step && s_q.ctrl[CTRL_EN_BIT]) begin
            // flow times factor; totalizer counts flow only
            s_d.tot = s_q.tot + 64'(flow_i) * STEP_US;
            s_d.acc = s_q.acc + add;
            if (s_d.acc >= ONE_PULSE[63:0]) begin
                s_d.acc = s_d.acc - ONE_PULSE[63:0];
                if (s_q.owed == 8'hff) ev[ST_OWED] = 1'b1;
                else s_d.owed = s_q.owed + 8'h1;
            end
        end
        // pulse generator: high for weff steps, then a pause one step longer, no overlap
        if (step) begin
            case (s_q.pg)
                PG_IDLE: begin
                    if (s_q.owed != 8'h0) begin
                        s_d.pg    = PG_HIGH;
                        s_d.pin   = 1'b1;
                        s_d.pgcnt = s_q.weff;
                        s_d.owed  = s_d.owed - 8'h1;
                        s_d.pcnt  = s_q.pcnt + 32'h1;
                    end
                end
                PG_HIGH: begin
                    if (s_q.pgcnt <= 17'h1) begin
                        s_d.pg    = PG_LOW;
                        s_d.pin   = 1'b0;
                        s_d.pgcnt = s_q.weff;
                    end else begin
                        s_d.pgcnt = s_q.pgcnt - 17'h1;
                    end
                end
                default: begin
                    if (s_q.pgcnt <= 17'h1) s_d.pg = PG_IDLE;
                    else s_d.pgcnt = s_q.pgcnt - 17'h1;
                end
            endcase
        end
        // events win over a clear in the same cycle
        s_d.status = s_d.status | ev;
        s_d.irq    = |(s_d.status & s_d.mask);
    end

    // state register, frozen while ce_i is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q        <= '0;
            s_q.ctrl   <= CTRL_RST;
            s_q.range  <= RANGE_RST;
            s_q.cal    <= CAL_RST;
            s_q.pf     <= PF_RST;
            s_q.wset   <= PW_RST;
            s_q.weff   <= PW_RST;
            s_q.mask   <= MASK_RST;
            s_q.pg     <= PG_IDLE;
            s_q.ck     <= CK_IDLE;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign dat_o                    = s_q.dat;
    assign ack_o                    = s_q.ack;
    assign pulse_output_terminals_o = s_q.pin;
    assign irq_o                    = s_q.irq;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_range_lower_bound: assert property (
        s_q.range <= s_q.cal
            && 40'(s_q.range) * 40'(RANGE_DIV) >= 40'(s_q.cal)
            || $past(s_q.range) == s_q.range)
        else $error("range left its bounds");
    a_pf_bounds_kept: assert property (
        s_q.pf >= PF_MIN && s_q.pf <= PF_MAX)
        else $error("pulse factor out of bounds");
    a_pf_keeps_total: assert property (
        ce_i && wr && adr_i == OFS_PFACT && !step
            |=> s_q.tot == $past(s_q.tot))
        else $error("totalizer moved on factor change");
    a_width_in_span: assert property (
        s_q.wset >= 17'h4 && s_q.wset <= 17'd62500)
        else $error("width setting out of span");
    a_width_whole_steps: assert property (
        ce_i && step && s_q.pg == PG_IDLE && s_q.owed != 8'h0
            |=> s_q.pin && s_q.pgcnt == $past(s_q.weff))
        else $error("pulse not started with step width");
    a_clamp_flags_warn: assert property (
        s_q.weff != s_q.wset && $changed(s_q.weff) && !$past(wr)
            |-> s_q.status[ST_CLAMP])
        else $error("clamp without warning");
    a_high_freq_error: assert property (
        ce_i && s_q.ck == CK_DONE && f130 > FHIGH_UHZ * OVR_DEN
            |=> s_q.status[ST_FHIGH])
        else $error("missing error -40");
    a_entry_reject_keep: assert property (
        ce_i && wr && adr_i == OFS_WIDTH
            && wprod(pw_steps, fprod, OVR_NUM) > ONE_PULSE * ENTRY_PCT
            |=> $stable(s_q.wset) && s_q.status[ST_WREJ])
        else $error("oversized width accepted");
    a_low_freq_error: assert property (
        ce_i && s_q.ck == CK_DONE && 96'(fprod) < FLOW_UHZ
            |=> s_q.status[ST_FLOW])
        else $error("missing error -41");
    // short pulse against its pause in active mode is reported
    a_ratio_flag_set: assert property (
        ce_i && s_q.ck == CK_DONE && s_q.ctrl[CTRL_ACTIVE_BIT]
            && fprod != 64'h0 && f130 <= FACT_UHZ * OVR_DEN
            && wprod(s_q.wset, fprod, RATIO_DIV) < ONE_PULSE
            |=> s_q.status[ST_RATIO])
        else $error("short pulse ratio not flagged");
    // every pulse put on the terminals is counted once
    a_pulse_counted: assert property (
        ce_i && step && s_q.pg == PG_IDLE && s_q.owed != 8'h0
            |=> s_q.pcnt == $past(s_q.pcnt) + 32'h1)
        else $error("started pulse not counted");
endmodule // sfp_pulse_out

// File: test/sfp_counter_model.sv
`timescale 1ns/10ps
// external pulse counter on the pulse output terminals
module sfp_counter_model (
    // clock, reset and terminal level
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pulse_i,
    // pulses seen and clocks high of the last pulse
    output int        count_o,
    output int        width_o
);
    logic prev_q;  // terminal level one clock ago
    int   run_q;   // clocks high so far
    // count rising edges, time each high phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // terminal idles low, so no false edge after reset
            prev_q  <= 1'b0;
            run_q   <= 0;
            count_o <= 0;
            width_o <= 0;
        end else begin
            prev_q <= pulse_i;
            if (pulse_i && !prev_q) begin
                count_o <= count_o + 1;
                run_q   <= 1;
            end else if (pulse_i) begin
                run_q <= run_q + 1;
            end else if (prev_q) begin
                width_o <= run_q;
            end
        end
    end
endmodule // sfp_counter_model

// File: test/sfp_pulse_out_test.sv
`timescale 1ns/10ps
// bench: bus checks of the settings, then a timed pulse run
module sfp_pulse_out_test
    import sfp_pkg::*;
;
    logic        clk_i;
    logic        rst_i  = 1'b1;
    logic        cyc_i  = 1'b0;
    logic        stb_i  = 1'b0;
    logic        we_i   = 1'b0;
    logic [7:0]  adr_i  = 8'h00;
    logic [31:0] dat_i  = 32'h0;
    logic [31:0] flow_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        pulse_output_terminals_o;
    logic        irq_o;
    logic [31:0] rdata;  // last read word
    logic [31:0] v;      // last accepted width entry
    logic [63:0] tot;    // totalizer snapshot
    int          cnt_n;
    int          wid_n;
    int          failures    = 0;
    int          check_count = 0;
    // design, bus enables and clock enable tied on
    sfp_pulse_out DUT (.clk_i, .rst_i, .ce_i(1'b1), .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .flow_i,
        .pulse_output_terminals_o, .irq_o);
    // far-side counter
    sfp_counter_model counter (.clk_i, .rst_i,
        .pulse_i(pulse_output_terminals_o), .count_o(cnt_n), .width_o(wid_n));
    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // width entry rounded up to whole steps
    function automatic logic [31:0] steps(input logic [31:0] us);
        return (us + 32'h1f) / 32'h20;
    endfunction
    // half period in steps for a rate in micro-hertz
    function automatic logic [31:0] half(input logic [95:0] f);
        return 32'(ONE_PULSE / (96'h40 * f));
    endfunction
    // whole pulses owed for a total and a factor
    function automatic logic [63:0] owed(input logic [63:0] t,
                                         input logic [63:0] p);
        return 64'((96'(t) * 96'(p)) / ONE_PULSE);
    endfunction
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rdata = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) begin
            failures++;
            summarize();
        end
    endtask
    // write, then let the settings check finish
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        repeat (100) @(posedge clk_i);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(rdata, e);
    endtask
    task automatic rbit(input int b, input logic e);
        bus(1'b0, OFS_STATUS, 32'h0);
        check(rdata[b], e);
    endtask
    // refused entry keeps the old value and flags it
    task automatic rej(input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] keep, input int b);
        wr(OFS_STATUS, 32'hff);
        wr(a, d);
        rchk(a, keep);
        rbit(b, 1'b1);
    endtask
    initial begin
        void'($urandom(50));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(OFS_RANGE, RANGE_RST);
        rchk(OFS_PFACT, PF_RST);
        rchk(OFS_WIDTH, 32'(PW_RST));
        rchk(8'h3c, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'h64 : 32'h64 + $urandom_range(4000);
            wr(OFS_WIDTH, v);
            rchk(OFS_WIDTH, steps(v));
        end
        rej(OFS_WIDTH, 32'h63, steps(v), ST_WREJ);
        rej(OFS_WIDTH, 32'h1e8481, steps(v), ST_WREJ);
        rej(OFS_WIDTH, 32'h2710, steps(v), ST_WREJ);
        rej(OFS_RANGE, 32'h1387, RANGE_RST, ST_RREJ);
        rej(OFS_RANGE, 32'h186a1, RANGE_RST, ST_RREJ);
        rej(OFS_PFACT, 32'h0, PF_RST, ST_PREJ);
        rej(OFS_PFACT, 32'hf4241, PF_RST, ST_PREJ);
        wr(OFS_WIDTH, 32'h1770);
        rchk(OFS_WIDTH, half(96'(RANGE_RST) * 96'(PF_RST)));
        rbit(ST_CLAMP, 1'b1);
        $display("entry limits done");
        wr(OFS_CAL, 32'hbb8);
        wr(OFS_RANGE, 32'h96);
        rchk(OFS_RANGE, 32'h96);
        wr(OFS_PFACT, 32'h1);
        rbit(ST_FLOW, 1'b1);
        wr(OFS_PFACT, 32'h2);
        wr(OFS_STATUS, 32'hff);
        rbit(ST_FLOW, 1'b0);
        wr(OFS_CAL, CAL_RST);
        wr(OFS_RANGE, RANGE_RST);
        wr(OFS_PFACT, 32'h963d);
        wr(OFS_STATUS, 32'hff);
        rbit(ST_FHIGH, 1'b0);
        wr(OFS_PFACT, 32'h963e);
        rbit(ST_FHIGH, 1'b1);
        $display("frequency limits done");
        wr(OFS_MASK, 32'h8);
        wr(OFS_WIDTH, 32'h63);
        check(irq_o, 1'b1);
        wr(OFS_MASK, 32'h0);
        check(irq_o, 1'b0);
        wr(OFS_PFACT, 32'ha);
        wr(OFS_CTRL, 32'h2);
        wr(OFS_WIDTH, 32'h186a0);
        rbit(ST_RATIO, 1'b1);
        $display("interrupt and ratio done");
        wr(OFS_CTRL, 32'h0);
        wr(OFS_RANGE, 32'h1388);
        wr(OFS_PFACT, 32'h186a0);
        wr(OFS_WIDTH, 32'h64);
        flow_i <= 32'h7a12 + $urandom_range(3000);
        wr(OFS_CTRL, 32'h1);
        repeat (32 * TICK_CYC) @(posedge clk_i);
        wr(OFS_CTRL, 32'h0);
        repeat (12 * TICK_CYC) @(posedge clk_i);
        bus(1'b0, OFS_TOT_LO, 32'h0);
        tot[31:0] = rdata;
        bus(1'b0, OFS_TOT_HI, 32'h0);
        tot[63:32] = rdata;
        rchk(OFS_PCOUNT, 32'(owed(tot, 64'h186a0)));
        check(64'(cnt_n), owed(tot, 64'h186a0));
        check(tot % (64'(flow_i) * 64'h20), 64'h0);
        check(64'(wid_n), 64'(4 * TICK_CYC));
        wr(OFS_PFACT, PF_RST);
        rchk(OFS_TOT_LO, tot[31:0]);
        $display("pulse run done");
        summarize();
    end
endmodule // sfp_pulse_out_test
